// ==== branch_compare_skip_exec.sv ====
`timescale 1ns/1ps

// How it works
// - Relative jump: PC+k+1, two cycles, flags kept.
// - Absolute jump: PC from instruction, three cycles.
// - Relative call: PC+k+1, three cycles, flags kept.
// - Pointer call: PC from pointer, three cycles.
// - Absolute call: constant target, four cycles.
// - Subroutine exit: PC from stack, four cycles.
// - Equal compare bypass skips next when equal.
// - Register compare sets Z N V C H.
// - Compare with borrow subtracts carry too.
// - Immediate compare subtracts constant, sets flags.
// - Register bit test bypasses next instruction.
// - I/O bit test bypasses next instruction.
// - Interrupt exit pops PC, sets interrupt enable.
// - Flag branch: 1 cycle untaken, 2 taken.
module branch_compare_skip_exec (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        start_in,
  input  wire logic [15:0] instr_in,
  input  wire logic [15:0] instr2_in,
  input  wire logic [15:0] next_word_in,
  input  wire logic [7:0]  rd_value_in,
  input  wire logic [7:0]  rr_value_in,
  input  wire logic [7:0]  io_value_in,
  input  wire logic [15:0] pointer_in,
  output logic             ready_out,
  output logic             done_out,
  output logic [4:0]       rd_addr_out,
  output logic [4:0]       rr_addr_out,
  output logic [4:0]       io_addr_out,
  output logic [15:0]      pc_out,
  output logic [7:0]       status_flags_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [15:0] w, input logic [15:0] m, input logic [15:0] c);
    hit = (w & m) == c;
  endfunction

  // Flags of d - r - cin; Z is chained for the borrow form so multi-byte compares work.
  function automatic logic [7:0] cmp_flags(input logic [7:0] f, input logic [7:0] d, input logic [7:0] r,
                                           input logic cin, input logic chain);
    logic [7:0] res;
    logic [7:0] o;
    res = d - r - {7'h00, cin};
    o = f;
    o[branch_pkg::FLAG_H] = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
    o[branch_pkg::FLAG_C] = (~d[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~d[7]);
    o[branch_pkg::FLAG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
    o[branch_pkg::FLAG_N] = res[7];
    o[branch_pkg::FLAG_S] = res[7] ^ o[branch_pkg::FLAG_V];
    o[branch_pkg::FLAG_Z] = (res == 8'h00) & (~chain | f[branch_pkg::FLAG_Z]);
    cmp_flags = o;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } exec_state_t;

  typedef struct packed {
    exec_state_t            state;
    branch_pkg::count_t     left;
    branch_pkg::pc_t        pc;
    branch_pkg::pc_t        target;
    branch_pkg::flags_t     flags;
    logic                   from_stack;
    logic                   set_int;
    branch_pkg::stack_ptr_t sp;
    logic                   done;
  } exec_t;

  exec_t s_q;
  exec_t s_d;

  logic                   push;
  branch_pkg::pc_t        push_val;
  branch_pkg::stack_ptr_t pop_addr;
  logic [15:0]            stack_top;

  // ---------------------------------------------------------------
  // Decode and execute
  // ---------------------------------------------------------------
  logic               next_two;
  logic               taken;
  logic               is_pop;
  branch_pkg::count_t cyc;
  branch_pkg::pc_t    tgt;
  branch_pkg::pc_t    rel12;
  branch_pkg::pc_t    rel7;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    push = 1'b0;
    push_val = s_q.pc + branch_pkg::PC_STEP_ONE;
    next_two = hit(next_word_in, branch_pkg::MASK_ABS, branch_pkg::CODE_ABS_JUMP)
             | hit(next_word_in, branch_pkg::MASK_ABS, branch_pkg::CODE_ABS_CALL)
             | hit(next_word_in, branch_pkg::MASK_LDST, branch_pkg::CODE_LD_DIR)
             | hit(next_word_in, branch_pkg::MASK_LDST, branch_pkg::CODE_ST_DIR);
    taken = 1'b0;
    is_pop = 1'b0;
    cyc = branch_pkg::CYC_ONE;
    tgt = s_q.pc + branch_pkg::PC_STEP_ONE;
    rel12 = s_q.pc + {{4{instr_in[11]}}, instr_in[11:0]} + branch_pkg::PC_STEP_ONE;
    rel7 = s_q.pc + {{9{instr_in[9]}}, instr_in[9:3]} + branch_pkg::PC_STEP_ONE;
    case (s_q.state)
      ST_IDLE: begin
        if (start_in) begin
          s_d.set_int = 1'b0;
          if (hit(instr_in, branch_pkg::MASK_K12, branch_pkg::CODE_REL_JUMP)) begin
            tgt = rel12;
            cyc = branch_pkg::CYC_REL_JUMP;
          end else if (hit(instr_in, branch_pkg::MASK_K12, branch_pkg::CODE_REL_CALL)) begin
            tgt = rel12;
            cyc = branch_pkg::CYC_REL_CALL;
            push = 1'b1;
          end else if (hit(instr_in, branch_pkg::MASK_FULL, branch_pkg::CODE_PTR_JUMP)) begin
            tgt = pointer_in;
            cyc = branch_pkg::CYC_PTR_JUMP;
          end else if (hit(instr_in, branch_pkg::MASK_FULL, branch_pkg::CODE_PTR_CALL)) begin
            tgt = pointer_in;
            cyc = branch_pkg::CYC_PTR_CALL;
            push = 1'b1;
          end else if (hit(instr_in, branch_pkg::MASK_ABS, branch_pkg::CODE_ABS_JUMP)) begin
            tgt = instr2_in;
            cyc = branch_pkg::CYC_ABS_JUMP;
          end else if (hit(instr_in, branch_pkg::MASK_ABS, branch_pkg::CODE_ABS_CALL)) begin
            tgt = instr2_in;
            cyc = branch_pkg::CYC_ABS_CALL;
            push = 1'b1;
            push_val = s_q.pc + branch_pkg::PC_STEP_TWO;
          end else if (hit(instr_in, branch_pkg::MASK_FULL, branch_pkg::CODE_SUB_EXIT)) begin
            is_pop = 1'b1;
            cyc = branch_pkg::CYC_RETURN;
          end else if (hit(instr_in, branch_pkg::MASK_FULL, branch_pkg::CODE_INT_EXIT)) begin
            is_pop = 1'b1;
            s_d.set_int = 1'b1;
            cyc = branch_pkg::CYC_RETURN;
          end else if (hit(instr_in, branch_pkg::MASK_RR, branch_pkg::CODE_CMP_EQ)) begin
            taken = rd_value_in == rr_value_in;
          end else if (hit(instr_in, branch_pkg::MASK_RR, branch_pkg::CODE_CMP)) begin
            s_d.flags = cmp_flags(s_q.flags, rd_value_in, rr_value_in, 1'b0, 1'b0);
          end else if (hit(instr_in, branch_pkg::MASK_RR, branch_pkg::CODE_CMP_C)) begin
            s_d.flags = cmp_flags(s_q.flags, rd_value_in, rr_value_in, s_q.flags[branch_pkg::FLAG_C], 1'b1);
          end else if (hit(instr_in, branch_pkg::MASK_K12, branch_pkg::CODE_CMP_IMM)) begin
            s_d.flags = cmp_flags(s_q.flags, rd_value_in, {instr_in[11:8], instr_in[3:0]}, 1'b0, 1'b0);
          end else if (hit(instr_in, branch_pkg::MASK_REG_BIT, branch_pkg::CODE_RBIT_CLR)) begin
            taken = ~rd_value_in[instr_in[2:0]];
          end else if (hit(instr_in, branch_pkg::MASK_REG_BIT, branch_pkg::CODE_RBIT_SET)) begin
            taken = rd_value_in[instr_in[2:0]];
          end else if (hit(instr_in, branch_pkg::MASK_IO_BIT, branch_pkg::CODE_IBIT_CLR)) begin
            taken = ~io_value_in[instr_in[2:0]];
          end else if (hit(instr_in, branch_pkg::MASK_IO_BIT, branch_pkg::CODE_IBIT_SET)) begin
            taken = io_value_in[instr_in[2:0]];
          end else if (hit(instr_in, branch_pkg::MASK_RR, branch_pkg::CODE_BR_SET)
                       || hit(instr_in, branch_pkg::MASK_RR, branch_pkg::CODE_BR_CLR)) begin
            if (s_q.flags[instr_in[2:0]] == ~instr_in[10]) begin
              tgt = rel7;
              cyc = branch_pkg::CYC_BR_TAKEN;
            end
          end
          // Every skip form shares the same step, sized by the bypassed instruction.
          if (taken) begin
            tgt = s_q.pc + (next_two ? branch_pkg::PC_STEP_THR : branch_pkg::PC_STEP_TWO);
            cyc = next_two ? branch_pkg::CYC_SKIP_TWO : branch_pkg::CYC_SKIP_ONE;
          end
          if (push) begin
            s_d.sp = s_q.sp + 1'b1;
          end
          if (is_pop) begin
            s_d.sp = s_q.sp - 1'b1;
          end
          s_d.from_stack = is_pop;
          if (cyc == branch_pkg::CYC_ONE) begin
            s_d.pc = tgt;
            s_d.done = 1'b1;
          end else begin
            s_d.target = tgt;
            s_d.left = cyc - branch_pkg::CYC_ONE;
            s_d.state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        s_d.left = s_q.left - branch_pkg::CYC_ONE;
        if (s_q.left == branch_pkg::CYC_ONE) begin
          // The stack word is read one cycle late, so it is only taken at the final edge.
          s_d.pc = s_q.from_stack ? stack_top : s_q.target;
          if (s_q.set_int) begin
            s_d.flags[branch_pkg::FLAG_I] = 1'b1;
          end
          s_d.done = 1'b1;
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '{state: ST_IDLE, left: '0, pc: branch_pkg::PC_RESET, target: branch_pkg::PC_RESET,
               flags: branch_pkg::FLAGS_RESET, from_stack: 1'b0, set_int: 1'b0, sp: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  // The pointer wraps after sixteen nested calls; deeper nesting overwrites the oldest entry.
  assign pop_addr = s_q.sp - 1'b1;

  return_stack_mem u_stack (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .write_en_in   (push),
    .write_addr_in (s_q.sp),
    .write_data_in (push_val),
    .read_addr_in  (s_q.state == ST_IDLE ? pop_addr : s_q.sp),
    .read_data_out (stack_top)
  );

  assign ready_out        = s_q.state == ST_IDLE;
  assign done_out         = s_q.done;
  assign pc_out           = s_q.pc;
  assign status_flags_out = s_q.flags;
  assign rd_addr_out      = hit(instr_in, branch_pkg::MASK_K12, branch_pkg::CODE_CMP_IMM) ?
                            {1'b1, instr_in[7:4]} : instr_in[8:4];
  assign rr_addr_out      = {instr_in[9], instr_in[3:0]};
  assign io_addr_out      = instr_in[7:3];

endmodule

// ==== branch_pkg.sv ====
package branch_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  typedef logic [15:0] pc_t;
  typedef logic [7:0]  flags_t;
  typedef logic [2:0]  count_t;
  localparam int unsigned STACK_ADDR_W = 4;
  typedef logic [STACK_ADDR_W-1:0] stack_ptr_t;

  localparam pc_t    PC_RESET    = 16'h0000;
  localparam flags_t FLAGS_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Status flag bit positions
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_I = 7;

  // ---------------------------------------------------------------
  // Opcode matching: an opcode matches when (word & mask) == code
  // ---------------------------------------------------------------
  localparam logic [15:0] MASK_K12      = 16'hf000;
  localparam logic [15:0] CODE_REL_JUMP = 16'hc000;
  localparam logic [15:0] CODE_REL_CALL = 16'hd000;
  localparam logic [15:0] MASK_FULL     = 16'hffff;
  localparam logic [15:0] CODE_PTR_JUMP = 16'h9409;
  localparam logic [15:0] CODE_PTR_CALL = 16'h9509;
  localparam logic [15:0] CODE_SUB_EXIT = 16'h9508;
  localparam logic [15:0] CODE_INT_EXIT = 16'h9518;
  localparam logic [15:0] MASK_ABS      = 16'hfe0e;
  localparam logic [15:0] CODE_ABS_JUMP = 16'h940c;
  localparam logic [15:0] CODE_ABS_CALL = 16'h940e;
  localparam logic [15:0] MASK_LDST     = 16'hfe0f;
  localparam logic [15:0] CODE_LD_DIR   = 16'h9000;
  localparam logic [15:0] CODE_ST_DIR   = 16'h9200;
  localparam logic [15:0] MASK_RR       = 16'hfc00;
  localparam logic [15:0] CODE_CMP_EQ   = 16'h1000;
  localparam logic [15:0] CODE_CMP      = 16'h1400;
  localparam logic [15:0] CODE_CMP_C    = 16'h0400;
  localparam logic [15:0] CODE_CMP_IMM  = 16'h3000;
  localparam logic [15:0] MASK_REG_BIT  = 16'hfe08;
  localparam logic [15:0] CODE_RBIT_CLR = 16'hfc00;
  localparam logic [15:0] CODE_RBIT_SET = 16'hfe00;
  localparam logic [15:0] MASK_IO_BIT   = 16'hff00;
  localparam logic [15:0] CODE_IBIT_CLR = 16'h9900;
  localparam logic [15:0] CODE_IBIT_SET = 16'h9b00;
  localparam logic [15:0] CODE_BR_SET   = 16'hf000;
  localparam logic [15:0] CODE_BR_CLR   = 16'hf400;

  // ---------------------------------------------------------------
  // Cycle counts
  // ---------------------------------------------------------------
  localparam count_t CYC_ONE        = 3'h1;
  localparam count_t CYC_REL_JUMP   = 3'h2;
  localparam count_t CYC_PTR_JUMP   = 3'h2;
  localparam count_t CYC_ABS_JUMP   = 3'h3;
  localparam count_t CYC_REL_CALL   = 3'h3;
  localparam count_t CYC_PTR_CALL   = 3'h3;
  localparam count_t CYC_ABS_CALL   = 3'h4;
  localparam count_t CYC_RETURN     = 3'h4;
  localparam count_t CYC_SKIP_ONE   = 3'h2;
  localparam count_t CYC_SKIP_TWO   = 3'h3;
  localparam count_t CYC_BR_TAKEN   = 3'h2;

  localparam pc_t PC_STEP_ONE = 16'h0001;
  localparam pc_t PC_STEP_TWO = 16'h0002;
  localparam pc_t PC_STEP_THR = 16'h0003;

endpackage

// ==== return_stack_mem.sv ====
`timescale 1ns/1ps

module return_stack_mem (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   write_en_in,
  input  wire branch_pkg::stack_ptr_t write_addr_in,
  input  wire branch_pkg::pc_t        write_data_in,
  input  wire branch_pkg::stack_ptr_t read_addr_in,
  output logic [15:0]                 read_data_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0][15:0] words;
    logic [15:0]       rdata;
  } mem_state_t;

  mem_state_t s_q;
  mem_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.words[read_addr_in];
    if (write_en_in) begin
      s_d.words[write_addr_in] = write_data_in;
    end
  end

  // Contents are not cleared by reset; only the read register is.
  always_ff @(posedge clk_in) begin
    s_q.words <= s_d.words;
    if (reset_in) begin
      s_q.rdata <= branch_pkg::PC_RESET;
    end else begin
      s_q.rdata <= s_d.rdata;
    end
  end

  assign read_data_out = s_q.rdata;

endmodule

// ==== operand_file_model.sv ====
`timescale 1ns/1ps
// ----
// Operand files
// ----
// Contents are fixed so expectations stay simple; no write path exists.
module operand_file_model (
  input  wire logic [4:0] rd_addr_in,
  input  wire logic [4:0] rr_addr_in,
  input  wire logic [4:0] io_addr_in,
  output logic [7:0]      rd_value_out,
  output logic [7:0]      rr_value_out,
  output logic [7:0]      io_value_out
);
  assign rd_value_out = {rd_addr_in[3:0], rd_addr_in[3:0]};
  assign rr_value_out = {rr_addr_in[3:0], rr_addr_in[3:0]};
  assign io_value_out = {io_addr_in, 3'h5};
endmodule

// ==== branch_exec_props.sv ====
`timescale 1ns/1ps
// ----
// Port checks
// ----
module branch_exec_props (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        start_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] instr2_in,
  input wire logic [7:0]  rd_value_in,
  input wire logic [7:0]  rr_value_in,
  input wire logic [15:0] pointer_in,
  input wire logic        ready_out,
  input wire logic        done_out,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  status_flags_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic        tk;
  logic [15:0] k12;
  assign tk  = start_in && ready_out;
  assign k12 = {{4{instr_in[11]}}, instr_in[11:0]};
  rel_jump_a: assert property (tk && instr_in[15:12] == 4'hc |=> !ready_out ##1 done_out
    && pc_out == $past(pc_out, 2) + $past(k12, 2) + 16'h1 && status_flags_out == $past(status_flags_out, 2))
    else $error("relative jump wrong");
  ptr_jump_a: assert property (tk && instr_in == 16'h9409 |=> !ready_out ##1 done_out
    && pc_out == $past(pointer_in, 2)) else $error("pointer jump wrong");
  abs_jump_a: assert property (tk && instr_in == 16'h940c |=> !ready_out [*2] ##1 done_out
    && pc_out == $past(instr2_in, 3)) else $error("absolute jump wrong");
  rel_call_a: assert property (tk && instr_in[15:12] == 4'hd |=> !ready_out [*2] ##1 done_out
    && pc_out == $past(pc_out, 3) + $past(k12, 3) + 16'h1) else $error("relative call wrong");
  ptr_call_a: assert property (tk && instr_in == 16'h9509 |=> !ready_out [*2] ##1 done_out
    && pc_out == $past(pointer_in, 3)) else $error("pointer call wrong");
  abs_call_a: assert property (tk && instr_in == 16'h940e |=> !ready_out [*3] ##1 done_out
    && pc_out == $past(instr2_in, 4)) else $error("absolute call wrong");
  sub_exit_a: assert property (tk && instr_in == 16'h9508 |=> !ready_out [*3] ##1 done_out
    && status_flags_out == $past(status_flags_out, 4)) else $error("return wrong");
  int_exit_a: assert property (tk && instr_in == 16'h9518 |=> !ready_out [*3] ##1 done_out
    && status_flags_out[7]) else $error("interrupt return wrong");
  reg_compare_a: assert property (tk && instr_in[15:10] == 6'h05 |=> done_out && ready_out
    && pc_out == $past(pc_out) + 16'h1 && status_flags_out[1] == ($past(rd_value_in) == $past(rr_value_in))
    && status_flags_out[0] == ($past(rd_value_in) < $past(rr_value_in))) else $error("compare wrong");
  bypass_miss_a: assert property (tk && instr_in[15:10] == 6'h04 && rd_value_in != rr_value_in
    |=> done_out && pc_out == $past(pc_out) + 16'h1) else $error("unequal bypass wrong");
  cover property (tk && instr_in[15:12] == 4'hd);
  cover property (tk && instr_in == 16'h9518);
  cover property (tk && instr_in[15:10] == 6'h05);
endmodule
bind branch_compare_skip_exec branch_exec_props props_i (
  .clk_in(clk_in), .reset_in(reset_in), .start_in(start_in), .instr_in(instr_in),
  .instr2_in(instr2_in), .rd_value_in(rd_value_in), .rr_value_in(rr_value_in),
  .pointer_in(pointer_in), .ready_out(ready_out), .done_out(done_out), .pc_out(pc_out),
  .status_flags_out(status_flags_out));

// ==== branch_compare_skip_exec_tb.sv ====
`timescale 1ns/1ps
module branch_compare_skip_exec_tb;
  logic               clk_in = 1'b0;
  logic               reset_in = 1'b1;
  logic               start_in = 1'b0;
  logic [15:0]        instr_in = 16'h0;
  logic [15:0]        instr2_in = 16'h0;
  logic [15:0]        next_word_in = 16'h0;
  logic [15:0]        pointer_in = 16'h0;
  logic [7:0]         rd_v, rr_v, io_v;
  logic [4:0]         rd_a, rr_a, io_a;
  logic               ready_out, done_out;
  logic [15:0]        pc_out;
  logic [7:0]         status_flags_out;
  branch_pkg::pc_t    pc_exp = 16'h0;
  branch_pkg::flags_t fl_exp = 8'h0;
  int                 err_count = 0;
  int                 total_checks = 0;

  always #50 clk_in = ~clk_in;

  branch_compare_skip_exec DUT (.clk_in(clk_in), .reset_in(reset_in), .start_in(start_in),
    .instr_in(instr_in), .instr2_in(instr2_in), .next_word_in(next_word_in), .rd_value_in(rd_v),
    .rr_value_in(rr_v), .io_value_in(io_v), .pointer_in(pointer_in), .ready_out(ready_out),
    .done_out(done_out), .rd_addr_out(rd_a), .rr_addr_out(rr_a), .io_addr_out(io_a),
    .pc_out(pc_out), .status_flags_out(status_flags_out));
  operand_file_model far_i (.rd_addr_in(rd_a), .rr_addr_in(rr_a), .io_addr_in(io_a),
    .rd_value_out(rd_v), .rr_value_out(rr_v), .io_value_out(io_v));

  // ----
  // Shared tasks
  // ----
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_fl();
    check_val("flags", {8'h0, fl_exp}, {8'h0, status_flags_out});
  endtask

  // Called at a falling edge; start stays high so the next call issues back to back.
  task automatic run_op(input logic [15:0] op, w2, nw, tgt, input logic [2:0] n_exp);
    logic [2:0] n;
    n = 3'h1;
    instr_in = op;
    instr2_in = w2;
    next_word_in = nw;
    start_in = 1'b1;
    @(negedge clk_in);
    while (done_out !== 1'b1 && n < 3'h7) begin
      @(negedge clk_in);
      n = n + 3'h1;
    end
    check_val("cycles", {13'h0, n_exp}, {13'h0, n});
    check_val("pc", tgt, pc_out);
    pc_exp = tgt;
  endtask

  task automatic idle();
    start_in = 1'b0;
    @(negedge clk_in);
  endtask

  function automatic logic [7:0] sub_flags(input logic [7:0] a, b, input logic c, zin);
    logic [8:0] r;
    logic [7:0] f;
    r = {1'b0, a} - {1'b0, b} - {8'h0, c};
    f = fl_exp;
    f[0] = r[8];
    f[1] = (r[7:0] == 8'h00) & zin;
    f[2] = r[7];
    f[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[4] = f[2] ^ f[3];
    f[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return f;
  endfunction

  task automatic cmp_op(input logic [15:0] op, input logic [7:0] a, b, input logic chain);
    fl_exp = sub_flags(a, b, chain & fl_exp[0], ~chain | fl_exp[1]);
    run_op(op, 16'h0, 16'h0, pc_exp + 16'h1, 3'h1);
    chk_fl();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_jumps();
    run_op(16'hc010, 16'h0, 16'h0, 16'h0011, 3'h2);
    run_op(16'hcfff, 16'h0, 16'h0, 16'h0011, 3'h2);
    pointer_in = 16'h0400;
    run_op(16'h940c, 16'h1234, 16'h0, 16'h1234, 3'h3);
    run_op(16'h9409, 16'h0, 16'h0, 16'h0400, 3'h2);
    idle();
    chk_fl();
    $display("jumps done");
  endtask

  // Nested calls prove the pushed addresses come back in order.
  task automatic t_calls();
    run_op(16'hd020, 16'h0, 16'h0, 16'h0421, 3'h3);
    run_op(16'h940e, 16'h2000, 16'h0, 16'h2000, 3'h4);
    run_op(16'h9508, 16'h0, 16'h0, 16'h0423, 3'h4);
    run_op(16'h9508, 16'h0, 16'h0, 16'h0401, 3'h4);
    pointer_in = 16'h0600;
    run_op(16'h9509, 16'h0, 16'h0, 16'h0600, 3'h3);
    run_op(16'h9518, 16'h0, 16'h0, 16'h0402, 3'h4);
    fl_exp[7] = 1'b1;
    chk_fl();
    idle();
    $display("calls done");
  endtask

  task automatic t_compares();
    cmp_op(16'h1435, 8'h33, 8'h55, 1'b0);
    cmp_op(16'h0633, 8'h33, 8'h33, 1'b1);
    cmp_op(16'h1633, 8'h33, 8'h33, 1'b0);
    cmp_op(16'h0633, 8'h33, 8'h33, 1'b1);
    cmp_op(16'h3234, 8'h33, 8'h24, 1'b0);
    cmp_op(16'h3001, 8'h00, 8'h01, 1'b0);
    idle();
    $display("compares done");
  endtask

  task automatic t_skips();
    run_op(16'h1233, 16'h0, 16'h0000, pc_exp + 16'h2, 3'h2);
    run_op(16'h1233, 16'h0, 16'h940c, pc_exp + 16'h3, 3'h3);
    run_op(16'h1035, 16'h0, 16'h0000, pc_exp + 16'h1, 3'h1);
    run_op(16'hfc30, 16'h0, 16'h0000, pc_exp + 16'h1, 3'h1);
    run_op(16'hfe30, 16'h0, 16'h9000, pc_exp + 16'h3, 3'h3);
    run_op(16'hfc32, 16'h0, 16'h0000, pc_exp + 16'h2, 3'h2);
    run_op(16'h9911, 16'h0, 16'h0000, pc_exp + 16'h2, 3'h2);
    run_op(16'h9b10, 16'h0, 16'h9200, pc_exp + 16'h3, 3'h3);
    run_op(16'h9b11, 16'h0, 16'h0000, pc_exp + 16'h1, 3'h1);
    idle();
    chk_fl();
    $display("skips done");
  endtask

  task automatic t_branches();
    run_op(16'hf028, 16'h0, 16'h0, pc_exp + 16'h6, 3'h2);
    run_op(16'hf029, 16'h0, 16'h0, pc_exp + 16'h1, 3'h1);
    run_op(16'hf7e9, 16'h0, 16'h0, pc_exp - 16'h2, 3'h2);
    run_op(16'hf7e8, 16'h0, 16'h0, pc_exp + 16'h1, 3'h1);
    idle();
    chk_fl();
    $display("branches done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    check_val("pc", 16'h0, pc_out);
    check_val("idle", 16'h2, {14'h0, ready_out, done_out});
    chk_fl();
    t_jumps();
    t_calls();
    t_compares();
    t_skips();
    t_branches();
    stop_test();
  end

  // Tests need under a hundred cycles; a hang is cut off well after that.
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    stop_test();
  end
endmodule
